// ===== common/adcif_pkg.sv
// Constants and types shared by the converter's serial target interface.
// Assumes a 100 MHz system clock and a separate link-side sampling clock.
package adcif_pkg;

  // ****************************************
  // Clock and conversion timing
  // ****************************************
  localparam int CLOCK_NS = 10;
  localparam int CONV_NS_R240 = 4166667;
  localparam int CONV_NS_R60 = 16666667;
  localparam int CONV_NS_R30 = 33333333;
  localparam int CONV_NS_R15 = 66666667;
  localparam int CONV_CYC_R240 = CONV_NS_R240 / CLOCK_NS;
  localparam int CONV_CYC_R60 = CONV_NS_R60 / CLOCK_NS;
  localparam int CONV_CYC_R30 = CONV_NS_R30 / CLOCK_NS;
  localparam int CONV_CYC_R15 = CONV_NS_R15 / CLOCK_NS;
  localparam int CONV_CNT_W = 23;

  // ****************************************
  // Register layout and reset values
  // ****************************************
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] CONFIG_RESET = 8'h8c;
  localparam int CFG_START_READY_BIT = 7;
  localparam int CFG_SINGLE_SHOT_BIT = 4;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_GAIN_LSB = 0;
  localparam logic [1:0] RATE_240 = 2'h0;
  localparam logic [1:0] RATE_60 = 2'h1;
  localparam logic [1:0] RATE_30 = 2'h2;
  localparam logic [1:0] RATE_15 = 2'h3;
  localparam logic [1:0] GAIN_1 = 2'h0;

  // ****************************************
  // Serial bus constants
  // ****************************************
  localparam logic [6:0] DEFAULT_ADDR = 7'h48;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [7:0] GEN_CALL_RESET = 8'h06;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h3;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_ADDR = 3'h1,
    LK_ADDR_ACK = 3'h3,
    LK_WR = 3'h2,
    LK_WR_ACK = 3'h6,
    LK_RD = 3'h7,
    LK_RD_ACK = 3'h5
  } adcif_link_state_t;

  typedef enum logic {
    CV_IDLE = 1'b0,
    CV_RUN = 1'b1
  } adcif_conv_state_t;

endpackage

// ===== core/adcif_sync.sv
// Two-flop synchroniser for a bundle of independent level signals.
// Assumes each bit changes slowly compared with the destination clock.
`timescale 1ns/1ns
`default_nettype none
module adcif_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ===== core/adcif_top.sv
// Serial-bus target interface and register file of a delta-sigma converter.
// Assumes filter_data is on the system clock; scl/sda arrive from pins.
//
// Summary of operation
// - Result register 16-bit, zero until first conversion.
// - Config register resets to 8c hex.
// - Single-shot: writing one starts one conversion.
// - Continuous: written start/ready value is ignored.
// - Continuous: flag one once result read.
// - Single-shot: flag one while conversion runs.
// - Flag read describes result bytes just sent.
// - Mode bit one single-shot, zero continuous.
// - Rate select sets speed and result resolution.
// - Gain select picks gain one to eight.
// - Read returns two result bytes, then config.
// - Bytes beyond third read as ff, no effect.
// - Write: address then one byte into config.
// - Further write bytes are discarded.
// - Device answers one fixed bus address.
// - Continuous: store result, restart conversion immediately.
// - Single-shot done: store, clear flag, power down.
// - Power-up resets all configuration to defaults.
// - General call reset acts as power-up reset.
`timescale 1ns/1ns
`default_nettype none
module adcif_top #(
  parameter logic [6:0] DEVICE_ADDR = adcif_pkg::DEFAULT_ADDR,
  parameter int CONV_CYC_R240 = adcif_pkg::CONV_CYC_R240,
  parameter int CONV_CYC_R60 = adcif_pkg::CONV_CYC_R60,
  parameter int CONV_CYC_R30 = adcif_pkg::CONV_CYC_R30,
  parameter int CONV_CYC_R15 = adcif_pkg::CONV_CYC_R15
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic link_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] filter_data,
  output logic [1:0] gain_select,
  output logic [1:0] rate_select,
  output logic power_down
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [adcif_pkg::CONV_CNT_W-1:0] conv_period(input logic [1:0] rate);
    int cyc;
    case (rate)
      adcif_pkg::RATE_240: cyc = CONV_CYC_R240;
      adcif_pkg::RATE_60: cyc = CONV_CYC_R60;
      adcif_pkg::RATE_30: cyc = CONV_CYC_R30;
      default: cyc = CONV_CYC_R15;
    endcase
    conv_period = adcif_pkg::CONV_CNT_W'(cyc - 1);
  endfunction

  // Right-justifies and sign-extends the filter word to the rate's resolution.
  function automatic logic [15:0] scale_result(input logic [1:0] rate, input logic [15:0] raw);
    logic signed [15:0] s;
    s = $signed(raw);
    case (rate)
      adcif_pkg::RATE_240: scale_result = 16'(s >>> 4);
      adcif_pkg::RATE_60: scale_result = 16'(s >>> 2);
      adcif_pkg::RATE_30: scale_result = 16'(s >>> 1);
      default: scale_result = raw;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [1:0] idx, input logic [15:0] res,
                                           input logic [7:0] cfg);
    case (idx)
      2'h0: read_byte = res[15:8];
      2'h1: read_byte = res[7:0];
      2'h2: read_byte = cfg;
      default: read_byte = adcif_pkg::FILL_BYTE;
    endcase
  endfunction

  // ****************************************
  // Crossings
  // ****************************************
  logic [2:0] link_pins;
  logic [2:0] core_reqs;
  logic ack_sync;
  logic rd_req_q, wr_req_q, gcr_req_q, ack_q;
  logic [7:0] wr_data_q;
  logic [15:0] snap_res_q;
  logic [7:0] snap_cfg_q;

  adcif_sync #(.WIDTH(3)) u_pin_sync (
    .clk(link_clock),
    .reset_n(reset_n),
    .async_in({clock_enable, sda_in, scl_in}),
    .sync_out(link_pins)
  );

  adcif_sync #(.WIDTH(3)) u_req_sync (
    .clk(clock),
    .reset_n(reset_n),
    .async_in({gcr_req_q, wr_req_q, rd_req_q}),
    .sync_out(core_reqs)
  );

  adcif_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clock),
    .reset_n(reset_n),
    .async_in(ack_q),
    .sync_out(ack_sync)
  );

  // ****************************************
  // Link-side bus engine
  // ****************************************
  adcif_pkg::adcif_link_state_t lk_state_q, lk_state_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] byte_idx_q, byte_idx_d;
  logic rw_q, rw_d, gc_q, gc_d, first_q, first_d, nack_q, nack_d;
  logic oe_q, oe_d, scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  logic rd_req_d, wr_req_d, gcr_req_d, ack_seen_q, ack_seen_d;
  logic [7:0] wr_data_d, lk_cfg_q, lk_cfg_d;
  logic [15:0] lk_res_q, lk_res_d;
  logic scl, sda, lk_en, rise, fall, start_c, stop_c;

  always_comb begin
    scl = link_pins[0];
    sda = link_pins[1];
    lk_en = link_pins[2];
    rise = scl && !scl_p_q;
    fall = !scl && scl_p_q;
    start_c = scl && scl_p_q && sda_p_q && !sda;
    stop_c = scl && scl_p_q && !sda_p_q && sda;
    lk_state_d = lk_state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    byte_idx_d = byte_idx_q;
    rw_d = rw_q;
    gc_d = gc_q;
    first_d = first_q;
    nack_d = nack_q;
    oe_d = oe_q;
    scl_p_d = scl_p_q;
    sda_p_d = sda_p_q;
    rd_req_d = rd_req_q;
    wr_req_d = wr_req_q;
    gcr_req_d = gcr_req_q;
    ack_seen_d = ack_seen_q;
    wr_data_d = wr_data_q;
    lk_res_d = lk_res_q;
    lk_cfg_d = lk_cfg_q;
    if (lk_en) begin
      scl_p_d = scl;
      sda_p_d = sda;
      if (ack_sync != ack_seen_q) begin
        ack_seen_d = ack_sync;
        lk_res_d = snap_res_q;
        lk_cfg_d = snap_cfg_q;
      end
      if (start_c) begin
        lk_state_d = adcif_pkg::LK_ADDR;
        bit_cnt_d = 4'h0;
        oe_d = 1'b0;
      end else if (stop_c) begin
        lk_state_d = adcif_pkg::LK_IDLE;
        oe_d = 1'b0;
      end else begin
        case (lk_state_q)
          adcif_pkg::LK_ADDR: begin
            if (rise) begin
              shift_d = {shift_q[6:0], sda};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end else if (fall && bit_cnt_q == adcif_pkg::BITS_PER_BYTE) begin
              bit_cnt_d = 4'h0;
              if (shift_q[7:1] == DEVICE_ADDR || shift_q == adcif_pkg::GEN_CALL_ADDR) begin
                lk_state_d = adcif_pkg::LK_ADDR_ACK;
                oe_d = 1'b1;
                rw_d = shift_q[0];
                gc_d = (shift_q == adcif_pkg::GEN_CALL_ADDR);
                first_d = 1'b1;
                rd_req_d = shift_q[0] ? !rd_req_q : rd_req_q;
              end else begin
                lk_state_d = adcif_pkg::LK_IDLE;
              end
            end
          end
          adcif_pkg::LK_ADDR_ACK: begin
            if (fall) begin
              if (rw_q) begin
                shift_d = read_byte(2'h0, lk_res_q, lk_cfg_q);
                oe_d = !shift_d[7];
                byte_idx_d = 2'h1;
                lk_state_d = adcif_pkg::LK_RD;
              end else begin
                oe_d = 1'b0;
                lk_state_d = adcif_pkg::LK_WR;
              end
            end
          end
          adcif_pkg::LK_WR: begin
            if (rise) begin
              shift_d = {shift_q[6:0], sda};
              bit_cnt_d = bit_cnt_q + 4'h1;
            end else if (fall && bit_cnt_q == adcif_pkg::BITS_PER_BYTE) begin
              bit_cnt_d = 4'h0;
              oe_d = 1'b1;
              lk_state_d = adcif_pkg::LK_WR_ACK;
              first_d = 1'b0;
              if (first_q && gc_q && shift_q == adcif_pkg::GEN_CALL_RESET) begin
                gcr_req_d = !gcr_req_q;
              end else if (first_q && !gc_q) begin
                wr_data_d = shift_q;
                wr_req_d = !wr_req_q;
              end
            end
          end
          adcif_pkg::LK_WR_ACK: begin
            if (fall) begin
              oe_d = 1'b0;
              lk_state_d = adcif_pkg::LK_WR;
            end
          end
          adcif_pkg::LK_RD: begin
            if (rise) begin
              bit_cnt_d = bit_cnt_q + 4'h1;
            end else if (fall) begin
              if (bit_cnt_q == adcif_pkg::BITS_PER_BYTE) begin
                bit_cnt_d = 4'h0;
                oe_d = 1'b0;
                lk_state_d = adcif_pkg::LK_RD_ACK;
              end else begin
                shift_d = {shift_q[6:0], 1'b1};
                oe_d = !shift_d[7];
              end
            end
          end
          adcif_pkg::LK_RD_ACK: begin
            if (rise) begin
              nack_d = sda;
            end else if (fall) begin
              if (nack_q) begin
                lk_state_d = adcif_pkg::LK_IDLE;
              end else begin
                shift_d = read_byte(byte_idx_q, lk_res_q, lk_cfg_q);
                oe_d = !shift_d[7];
                if (byte_idx_q != adcif_pkg::LAST_BYTE_IDX) begin
                  byte_idx_d = byte_idx_q + 2'h1;
                end
                lk_state_d = adcif_pkg::LK_RD;
              end
            end
          end
          default: begin
            oe_d = 1'b0;
            lk_state_d = adcif_pkg::LK_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      lk_state_q <= adcif_pkg::LK_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      byte_idx_q <= 2'h0;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      gcr_req_q <= 1'b0;
      ack_seen_q <= 1'b0;
      wr_data_q <= 8'h00;
      lk_res_q <= adcif_pkg::RESULT_RESET;
      lk_cfg_q <= adcif_pkg::CONFIG_RESET;
    end else begin
      lk_state_q <= lk_state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      byte_idx_q <= byte_idx_d;
      rw_q <= rw_d;
      gc_q <= gc_d;
      first_q <= first_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      rd_req_q <= rd_req_d;
      wr_req_q <= wr_req_d;
      gcr_req_q <= gcr_req_d;
      ack_seen_q <= ack_seen_d;
      wr_data_q <= wr_data_d;
      lk_res_q <= lk_res_d;
      lk_cfg_q <= lk_cfg_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // ****************************************
  // Core registers and conversion sequencer
  // ****************************************
  adcif_pkg::adcif_conv_state_t cv_state_q, cv_state_d;
  logic [adcif_pkg::CONV_CNT_W-1:0] conv_cnt_q, conv_cnt_d;
  logic [15:0] conversion_result_q, conversion_result_d, snap_res_d;
  logic [7:0] snap_cfg_d, cfg_read;
  logic start_ready_flag_q, start_ready_flag_d, single_shot_select_q, single_shot_select_d;
  logic [1:0] rate_select_q, rate_select_d, gain_select_q, gain_select_d;
  logic [2:0] req_seen_q, req_seen_d;
  logic ack_d, rd_evt, wr_evt, gcr_evt, done;

  always_comb begin
    cfg_read = {start_ready_flag_q, 2'b00, single_shot_select_q, rate_select_q, gain_select_q};
    rd_evt = core_reqs[0] != req_seen_q[0];
    wr_evt = core_reqs[1] != req_seen_q[1];
    gcr_evt = core_reqs[2] != req_seen_q[2];
    done = cv_state_q == adcif_pkg::CV_RUN && conv_cnt_q >= conv_period(rate_select_q);
    cv_state_d = cv_state_q;
    conv_cnt_d = conv_cnt_q;
    conversion_result_d = conversion_result_q;
    start_ready_flag_d = start_ready_flag_q;
    single_shot_select_d = single_shot_select_q;
    rate_select_d = rate_select_q;
    gain_select_d = gain_select_q;
    snap_res_d = snap_res_q;
    snap_cfg_d = snap_cfg_q;
    ack_d = ack_q;
    req_seen_d = req_seen_q;
    if (clock_enable) begin
      req_seen_d = core_reqs;
      if (rd_evt) begin
        snap_res_d = conversion_result_q;
        snap_cfg_d = cfg_read;
        ack_d = !ack_q;
        if (!single_shot_select_q) begin
          start_ready_flag_d = 1'b1;
        end
      end
      if (cv_state_q == adcif_pkg::CV_RUN) begin
        conv_cnt_d = conv_cnt_q + 1'b1;
      end
      if (done) begin
        conversion_result_d = scale_result(rate_select_q, filter_data);
        conv_cnt_d = '0;
        start_ready_flag_d = 1'b0;
        if (single_shot_select_q) begin
          cv_state_d = adcif_pkg::CV_IDLE;
        end
      end
      if (wr_evt) begin
        single_shot_select_d = wr_data_q[adcif_pkg::CFG_SINGLE_SHOT_BIT];
        rate_select_d = wr_data_q[adcif_pkg::CFG_RATE_LSB+:2];
        gain_select_d = wr_data_q[adcif_pkg::CFG_GAIN_LSB+:2];
        if (wr_data_q[adcif_pkg::CFG_SINGLE_SHOT_BIT]) begin
          if (wr_data_q[adcif_pkg::CFG_START_READY_BIT] && cv_state_d == adcif_pkg::CV_IDLE) begin
            cv_state_d = adcif_pkg::CV_RUN;
            conv_cnt_d = '0;
            start_ready_flag_d = 1'b1;
          end
        end else if (cv_state_d == adcif_pkg::CV_IDLE) begin
          cv_state_d = adcif_pkg::CV_RUN;
          conv_cnt_d = '0;
        end
      end
      if (gcr_evt) begin
        cv_state_d = adcif_pkg::CV_RUN;
        conv_cnt_d = '0;
        conversion_result_d = adcif_pkg::RESULT_RESET;
        start_ready_flag_d = adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_START_READY_BIT];
        single_shot_select_d = adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_SINGLE_SHOT_BIT];
        rate_select_d = adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_RATE_LSB+:2];
        gain_select_d = adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_GAIN_LSB+:2];
      end
    end
  end

  // Continuous mode restarts by leaving the sequencer in run with a cleared count.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cv_state_q <= adcif_pkg::CV_RUN;
      conv_cnt_q <= '0;
      conversion_result_q <= adcif_pkg::RESULT_RESET;
      start_ready_flag_q <= adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_START_READY_BIT];
      single_shot_select_q <= adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_SINGLE_SHOT_BIT];
      rate_select_q <= adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_RATE_LSB+:2];
      gain_select_q <= adcif_pkg::CONFIG_RESET[adcif_pkg::CFG_GAIN_LSB+:2];
      snap_res_q <= adcif_pkg::RESULT_RESET;
      snap_cfg_q <= adcif_pkg::CONFIG_RESET;
      ack_q <= 1'b0;
      req_seen_q <= 3'h0;
    end else begin
      cv_state_q <= cv_state_d;
      conv_cnt_q <= conv_cnt_d;
      conversion_result_q <= conversion_result_d;
      start_ready_flag_q <= start_ready_flag_d;
      single_shot_select_q <= single_shot_select_d;
      rate_select_q <= rate_select_d;
      gain_select_q <= gain_select_d;
      snap_res_q <= snap_res_d;
      snap_cfg_q <= snap_cfg_d;
      ack_q <= ack_d;
      req_seen_q <= req_seen_d;
    end
  end

  assign gain_select = gain_select_q;
  assign rate_select = rate_select_q;
  assign power_down = cv_state_q == adcif_pkg::CV_IDLE;

endmodule
`default_nettype wire

// ===== bench/adcif_top_monitor.sv
// Port-level assertions for the converter's serial target interface.
// Assumes it is bound to adcif_top and that SCL is far slower than the link clock.
`timescale 1ns/1ns
`default_nettype none
module adcif_top_monitor #(
  parameter int CONV_CYC_R240 = 200
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic link_clock,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] filter_data,
  input wire logic [1:0] gain_select,
  input wire logic [1:0] rate_select,
  input wire logic power_down
);
  localparam int MIN_RUN = CONV_CYC_R240 - 4;
  logic [23:0] run_cnt_q;
  logic [23:0] run_cnt_d;

  // ****************************************
  // Cycles spent converting since power-down was left
  // ****************************************
  always_comb begin
    run_cnt_d = run_cnt_q;
    if (power_down) begin
      run_cnt_d = 24'h000000;
    end else if (clock_enable && run_cnt_q != 24'hffffff) begin
      run_cnt_d = run_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_cnt_q <= 24'h000000;
    end else begin
      run_cnt_q <= run_cnt_d;
    end
  end

  // ****************************************
  // Assertions and covers
  // ****************************************
  chk_drive_low_only: assert property (@(posedge link_clock) disable iff (!reset_n)
    sda_oe |-> !sda_out) else $error("Data line driven high.");
  chk_oe_scl_low: assert property (@(posedge link_clock) disable iff (!reset_n)
    $rose(sda_oe) |-> !scl_in) else $error("Data line changed while clock high.");
  chk_oe_bit_hold: assert property (@(posedge link_clock) disable iff (!reset_n)
    $rose(sda_oe) |=> sda_oe [*8]) else $error("Driven bit released too early.");
  chk_oe_reset_quiet: assert property (@(posedge link_clock) disable iff (!reset_n)
    $rose(reset_n) |-> !sda_oe) else $error("Data line driven after reset.");
  chk_reset_defaults: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> rate_select == 2'h3 && gain_select == 2'h0 && !power_down)
    else $error("Wrong settings after reset.");
  chk_cfg_by_ack: assert property (@(posedge clock) disable iff (!reset_n)
    $changed({rate_select, gain_select}) |-> sda_oe) else $error("Settings changed unasked.");
  chk_start_by_ack: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(power_down) |-> sda_oe) else $error("Conversion started unasked.");
  chk_conv_length: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(power_down) |-> run_cnt_q >= 24'(MIN_RUN)) else $error("Conversion too short.");
  cov_done: cover property (@(posedge clock) disable iff (!reset_n) $rose(power_down));
  cov_start: cover property (@(posedge clock) disable iff (!reset_n) $fell(power_down));
  cov_gain: cover property (@(posedge clock) disable iff (!reset_n) $changed(gain_select));
endmodule

bind adcif_top adcif_top_monitor #(.CONV_CYC_R240(CONV_CYC_R240)) u_monitor (
  .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .link_clock(link_clock),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .filter_data(filter_data), .gain_select(gain_select), .rate_select(rate_select),
  .power_down(power_down));
`default_nettype wire

// ===== bench/adcif_master_model.sv
// Behavioural serial-bus master standing on the far side of the converter.
// Assumes a pull-up on the data line; the bench resolves the wired-AND.
`timescale 1ns/1ns
`default_nettype none
module adcif_master_model #(
  parameter int QUARTER_NS = 650
) (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  logic [7:0] rx_byte;
  event rx_ev;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ****************************************
  // Bus conditions and bytes
  // ****************************************
  task automatic bus_bit(input logic b, output logic s);
    #(QUARTER_NS) sda_drv = b;
    #(QUARTER_NS) scl = 1'b1;
    #(QUARTER_NS) s = sda;
    #(QUARTER_NS) scl = 1'b0;
  endtask

  task automatic start();
    #(QUARTER_NS) sda_drv = 1'b0;
    #(QUARTER_NS) scl = 1'b0;
  endtask

  task automatic stop();
    #(QUARTER_NS) sda_drv = 1'b0;
    #(QUARTER_NS) scl = 1'b1;
    #(QUARTER_NS) sda_drv = 1'b1;
    #(QUARTER_NS);
  endtask

  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(b[i], s);
    end
    bus_bit(1'b1, s);
    rx_byte = {7'h00, s};
    ->rx_ev;
  endtask

  task automatic get_byte(input logic last);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, v[i]);
    end
    bus_bit(last, s);
    rx_byte = v;
    ->rx_ev;
  endtask
endmodule
`default_nettype wire

// ===== bench/adcif_top_bench.sv
// Self-checking bench for the converter's serial target interface.
// Assumes the master model on the bus and a pull-up on the data line.
`timescale 1ns/1ns
`default_nettype none
module adcif_top_bench;
  localparam logic [6:0] ADDR = adcif_pkg::DEFAULT_ADDR;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] filter_data;
  logic [15:0] fd;
  logic sda_oe, sda_out, scl, sda_drv, power_down;
  logic [1:0] gain_select, rate_select;
  wire logic sda_line;
  int fails = 0;
  int checked = 0;
  logic [7:0] exp_q[$];

  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  initial begin
    forever #5 clock = ~clock;
  end

  initial begin
    #7;
    forever #32 link_clock = ~link_clock;
  end

  adcif_top #(.CONV_CYC_R240(200), .CONV_CYC_R60(400), .CONV_CYC_R30(800),
    .CONV_CYC_R15(15000)) dut (
    .clock(clock), .reset_n(reset_n), .clock_enable(1'b1), .link_clock(link_clock),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .filter_data(filter_data), .gain_select(gain_select), .rate_select(rate_select),
    .power_down(power_down));

  adcif_master_model u_mst (.scl(scl), .sda_drv(sda_drv), .sda(sda_line));

  // ****************************************
  // Checking helpers and bus tasks
  // ****************************************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] conv(input logic [15:0] d, input int sh);
    return $signed(d) >>> sh;
  endfunction

  task automatic send(input logic [7:0] b, input logic nack);
    exp_q.push_back({7'h00, nack});
    u_mst.put_byte(b);
  endtask

  task automatic recv(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    u_mst.get_byte(last);
  endtask

  task automatic rd_regs(input logic [15:0] r, input logic [7:0] c, input logic extra);
    u_mst.start();
    send({ADDR, 1'b1}, 1'b0);
    recv(r[15:8], 1'b0);
    recv(r[7:0], 1'b0);
    recv(c, !extra);
    if (extra) recv(adcif_pkg::FILL_BYTE, 1'b1);
    u_mst.stop();
  endtask

  task automatic wr_cfg(input logic [7:0] c);
    u_mst.start();
    send({ADDR, 1'b0}, 1'b0);
    send(c, 1'b0);
  endtask

  task automatic wait_pd(input logic lvl);
    int n;
    n = 0;
    while (power_down !== lvl && n < 40000) begin
      @(posedge clock);
      n++;
    end
    check({15'h0000, power_down}, {15'h0000, lvl});
    if (n == 40000) report_and_stop();
  endtask

  initial begin
    forever begin
      @(u_mst.rx_ev);
      if (exp_q.size() == 0) begin
        fails++;
        $display("ERROR %0t: unexpected byte %h", $time, u_mst.rx_byte);
      end else begin
        check({8'h00, u_mst.rx_byte}, {8'h00, exp_q.pop_front()});
      end
    end
  end

  initial begin
    #1000000;
    fails++;
    $display("ERROR %0t: run did not finish", $time);
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hc50cdc75));
    fd = 16'($urandom);
    filter_data = fd;
    repeat (8) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge link_clock);
    rd_regs(16'h0000, adcif_pkg::CONFIG_RESET, 1'b1);
    u_mst.start();
    send({ADDR ^ 7'h01, 1'b1}, 1'b1);
    u_mst.stop();
    while ($time < 160000) @(posedge clock);
    rd_regs(conv(fd, 0), 8'h0c, 1'b0);
    rd_regs(conv(fd, 0), 8'h8c, 1'b0);
    for (int i = 3; i >= 0; i--) begin
      wr_cfg({4'h1, 2'(i), ~2'(i)});
      if (i == 0) send(8'h0c, 1'b0);
      u_mst.stop();
      repeat (20) @(posedge clock);
      check({14'h0000, rate_select}, {14'h0000, 2'(i)});
      check({14'h0000, gain_select}, {14'h0000, ~2'(i)});
    end
    wait_pd(1'b1);
    fd = 16'($urandom);
    @(posedge clock);
    #1 filter_data = fd;
    wr_cfg(8'h93);
    u_mst.stop();
    wait_pd(1'b1);
    rd_regs(conv(fd, 4), 8'h13, 1'b0);
    u_mst.start();
    send(adcif_pkg::GEN_CALL_ADDR, 1'b0);
    send(adcif_pkg::GEN_CALL_RESET, 1'b0);
    u_mst.stop();
    repeat (20) @(posedge clock);
    check({12'h000, rate_select, gain_select}, 16'h000c);
    check({15'h0000, power_down}, 16'h0000);
    rd_regs(16'h0000, adcif_pkg::CONFIG_RESET, 1'b1);
    check(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
